/* rtl/ddrsc_pkg.sv */
// shared constants and types for the strobe capture path
package ddrsc_pkg;

    // ==========================================
    // group geometry
    localparam int unsigned MAX_GROUPS = 8;
    localparam int unsigned NUM_BANKS = 4;
    localparam int unsigned GROUPS_PER_BANK = 2;
    localparam int unsigned DQ_WIDTH = 8;
    localparam int unsigned PIN_WIDTH = DQ_WIDTH + 1;
    localparam int unsigned STROBE_BIT = DQ_WIDTH;

    // ==========================================
    // timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned MAX_LINK_MHZ = 133;
    localparam int unsigned LINK_PERIOD_NS = 160;
    localparam int unsigned LINK_PERIOD_CYC = LINK_PERIOD_NS * CLK_MHZ / 1000;
    localparam int unsigned MIN_PERIOD_CYC = 8;
    localparam int unsigned CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // ==========================================
    // strobe phase shift
    localparam int unsigned PHASE_DDR_DEG = 90;
    localparam int unsigned PHASE_FCRAM_DEG = 72;
    localparam int unsigned FULL_TURN_DEG = 360;

    // ==========================================
    // carriers
    typedef struct packed {
        logic [DQ_WIDTH-1:0] rise;
        logic [DQ_WIDTH-1:0] fall;
    } ddrsc_pair_t;

    typedef struct packed {
        ddrsc_pair_t data;
        logic [1:0] mask;
    } ddrsc_wr_t;

endpackage

/* rtl/ddrsc_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ddrsc_sync
    import ddrsc_pkg::*;
#(
    parameter int unsigned WIDTH = PIN_WIDTH
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    // ==========================================
    // first stage is read only by the second
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            dout <= '0;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule

/* rtl/ddrsc_delay.sv */
// per-strobe phase delay: measures strobe period, fires capture points
`timescale 1ns/1ps
module ddrsc_delay
    import ddrsc_pkg::*;
#(
    parameter int unsigned DEF_PERIOD = LINK_PERIOD_CYC
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strobe,
    input wire logic fcram,
    output logic cap_rise,
    output logic cap_fall
);

    logic strobe_d_r;
    logic [CNT_W-1:0] per_cnt_r;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] wait_r;
    logic armed_r;
    logic kind_rise_r;
    logic [CNT_W+7:0] prod;
    logic [CNT_W-1:0] delay_cyc;
    logic edge_any;
    logic edge_rise;

    assign edge_rise = strobe & ~strobe_d_r;
    assign edge_any = strobe ^ strobe_d_r;

    // ==========================================
    // delay = period * phase / full turn, never below one cycle
    always_comb
    begin
        prod = {8'h00, period_r} * (fcram ? 16'(PHASE_FCRAM_DEG) : 16'(PHASE_DDR_DEG)); // [R6]
        delay_cyc = CNT_W'(prod / 16'(FULL_TURN_DEG));
        if (delay_cyc == CNT_ZERO)
        begin
            delay_cyc = CNT_ONE;
        end
    end

    // ==========================================
    // period measurement; idle gaps beyond counter range keep last period
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            strobe_d_r <= 1'b0;
            per_cnt_r <= CNT_MAX;
            period_r <= CNT_W'(DEF_PERIOD);
        end
        else
        begin
            strobe_d_r <= strobe;
            if (edge_rise)
            begin
                per_cnt_r <= CNT_ZERO;
                if (per_cnt_r != CNT_MAX && per_cnt_r >= CNT_W'(MIN_PERIOD_CYC - 1))
                begin
                    period_r <= per_cnt_r + CNT_ONE;
                end
            end
            else if (per_cnt_r != CNT_MAX)
            begin
                per_cnt_r <= per_cnt_r + CNT_ONE;
            end
        end
    end

    // ==========================================
    // capture point sits delay_cyc after each strobe edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wait_r <= CNT_ZERO;
            armed_r <= 1'b0;
            kind_rise_r <= 1'b0;
            cap_rise <= 1'b0;
            cap_fall <= 1'b0;
        end
        else
        begin
            cap_rise <= 1'b0;
            cap_fall <= 1'b0;
            if (edge_any)
            begin
                armed_r <= 1'b1;
                wait_r <= CNT_ONE;
                kind_rise_r <= edge_rise;
            end
            else if (armed_r)
            begin
                wait_r <= wait_r + CNT_ONE;
                if (wait_r == delay_cyc) // [R7]
                begin
                    armed_r <= 1'b0;
                    cap_rise <= kind_rise_r;
                    cap_fall <= ~kind_rise_r;
                end
            end
        end
    end

endmodule

/* rtl/ddrsc_top.sv */
// DDR strobe capture path: read capture, resync and write launch
//
// What this block does
// [R1] Works with DDR SDRAM and FCRAM at link rates up to 133 MHz.
// [R2] Strobe groups exist only in x8 mode, in every bank with memory pins.
// [R3] Each group has one strobe pin, eight data pins and one mask pin.
// [R4] A group's strobe clocks only its own eight data lines.
// [R5] At most eight groups, two per bank across four banks.
// [R6] Incoming strobe is delayed 90 degrees for DDR SDRAM or 72 for FCRAM.
// [R7] The delayed strobe lands centred in its group's data window unaided.
// [R8] The shifted strobe clocks its group's read data into core registers.
// [R9] Write data and its enable launch from a phase-shifted clock, not the strobe.
// [R10] Captured read data crosses to the core clock through a register chain.
// [R11] Read data is taken on both strobe edges, two words per strobe cycle.
// [R12] The memory drives its strobe edge-aligned with the read data it returns.
`timescale 1ns/1ps
module ddrsc_top
    import ddrsc_pkg::*;
#(
    parameter int unsigned NUM_GROUPS = MAX_GROUPS,
    parameter int unsigned LINK_MHZ = MAX_LINK_MHZ,
    parameter int unsigned PERIOD_CYC = LINK_PERIOD_CYC,
    parameter int unsigned RESYNC_STAGES = 2
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mem_is_fcram,
    input wire logic [NUM_GROUPS-1:0] dqs_i,
    input wire logic [NUM_GROUPS-1:0][DQ_WIDTH-1:0] dq_i,
    output logic [NUM_GROUPS-1:0] dqs_o,
    output logic [NUM_GROUPS-1:0] dqs_oe,
    output logic [NUM_GROUPS-1:0][DQ_WIDTH-1:0] dq_o,
    output logic [NUM_GROUPS-1:0] dq_oe,
    output logic [NUM_GROUPS-1:0] dm_o,
    output ddrsc_pair_t [NUM_GROUPS-1:0] rd_pair,
    output logic [NUM_GROUPS-1:0] rd_valid,
    input wire logic wr_en,
    input wire ddrsc_wr_t [NUM_GROUPS-1:0] wr_data,
    output logic wr_taken
);

    // ==========================================
    // elaboration checks
    localparam int unsigned HALF_CYC = PERIOD_CYC / 2;
    localparam int unsigned QUARTER_CYC = PERIOD_CYC / 4;
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
    localparam logic [CNT_W-1:0] SHIFT_AT = CNT_W'(HALF_CYC - QUARTER_CYC);

    initial
    begin
        if (NUM_GROUPS < 1 || NUM_GROUPS > NUM_BANKS * GROUPS_PER_BANK) // [R5]
        begin
            $error("group count out of range");
        end
        if (LINK_MHZ > MAX_LINK_MHZ) // [R1]
        begin
            $error("link rate above limit");
        end
        if (PERIOD_CYC < MIN_PERIOD_CYC || PERIOD_CYC > 32'(CNT_MAX)) // [R1]
        begin
            $error("link period not resolvable");
        end
        if (RESYNC_STAGES < 1)
        begin
            $error("resync chain needs a stage");
        end
    end

    // ==========================================
    // write clock divider with phase-shifted launch enable
    logic [CNT_W-1:0] div_r;
    logic base_tick;
    logic shift_tick;

    assign base_tick = (div_r == HALF_LAST);
    assign shift_tick = (div_r == SHIFT_AT);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div_r <= CNT_ZERO;
        end
        else if (base_tick)
        begin
            div_r <= CNT_ZERO;
        end
        else
        begin
            div_r <= div_r + CNT_ONE;
        end
    end

    // ==========================================
    // write sequencing: rise byte then fall byte per accepted pair
    logic wr_active_r;
    logic wr_second_r;
    ddrsc_wr_t [NUM_GROUPS-1:0] wr_hold_r;

    // launch runs on the shifted enable so data leads the strobe by one cycle less than a quarter period
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_active_r <= 1'b0;
            wr_second_r <= 1'b0;
            wr_taken <= 1'b0;
            wr_hold_r <= '0;
        end
        else
        begin
            wr_taken <= 1'b0;
            if (shift_tick) // [R9]
            begin
                wr_second_r <= ~wr_second_r;
                if (!wr_second_r)
                begin
                    wr_active_r <= wr_en;
                    wr_taken <= wr_en;
                    if (wr_en)
                    begin
                        wr_hold_r <= wr_data;
                    end
                end
            end
        end
    end

    // ==========================================
    // per-group read capture and write drive
    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++)
        begin : grp
            logic [PIN_WIDTH-1:0] pins_s;
            logic cap_rise;
            logic cap_fall;
            logic [DQ_WIDTH-1:0] rise_r; // [R2]
            ddrsc_pair_t pair_r;
            logic pair_vld_r;
            ddrsc_pair_t chain_r [RESYNC_STAGES];
            logic [RESYNC_STAGES-1:0] chain_vld_r;

            // strobe and its own eight lines share one sync, keeping their skew
            ddrsc_sync #(
                .WIDTH(PIN_WIDTH)
            ) u_sync (
                .clk(clk),
                .rst_n(rst_n),
                .din({dqs_i[g], dq_i[g]}), // [R3] [R4]
                .dout(pins_s)
            );

            // edge-aligned strobe is assumed, so one delay centres both edges
            ddrsc_delay #(
                .DEF_PERIOD(PERIOD_CYC)
            ) u_delay (
                .clk(clk),
                .rst_n(rst_n),
                .strobe(pins_s[STROBE_BIT]), // [R12]
                .fcram(mem_is_fcram), // [R6]
                .cap_rise(cap_rise),
                .cap_fall(cap_fall)
            );

            // capture on both delayed edges; pair completes on the fall
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    rise_r <= '0;
                    pair_r <= '0;
                    pair_vld_r <= 1'b0;
                end
                else
                begin
                    pair_vld_r <= 1'b0;
                    if (cap_rise) // [R8] [R11]
                    begin
                        rise_r <= pins_s[DQ_WIDTH-1:0]; // [R4]
                    end
                    if (cap_fall) // [R11]
                    begin
                        pair_r.rise <= rise_r;
                        pair_r.fall <= pins_s[DQ_WIDTH-1:0];
                        pair_vld_r <= 1'b1;
                    end
                end
            end

            // successive registers toward the core, costs fixed latency
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    chain_vld_r <= '0;
                    for (int s = 0; s < RESYNC_STAGES; s++)
                    begin
                        chain_r[s] <= '0;
                    end
                end
                else
                begin
                    chain_r[0] <= pair_r; // [R10]
                    chain_vld_r[0] <= pair_vld_r;
                    for (int s = 1; s < RESYNC_STAGES; s++)
                    begin
                        chain_r[s] <= chain_r[s-1]; // [R10]
                        chain_vld_r[s] <= chain_vld_r[s-1];
                    end
                end
            end

            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    rd_pair[g] <= '0;
                    rd_valid[g] <= 1'b0;
                end
                else
                begin
                    rd_pair[g] <= chain_r[RESYNC_STAGES-1];
                    rd_valid[g] <= chain_vld_r[RESYNC_STAGES-1];
                end
            end

            // data, mask and enable follow the shifted enable only
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    dq_o[g] <= '0;
                    dq_oe[g] <= 1'b0;
                    dm_o[g] <= 1'b0;
                end
                else if (shift_tick) // [R9]
                begin
                    if (!wr_second_r)
                    begin
                        dq_oe[g] <= wr_en;
                        dq_o[g] <= wr_en ? wr_data[g].data.rise : '0;
                        dm_o[g] <= wr_en & wr_data[g].mask[1];
                    end
                    else
                    begin
                        dq_oe[g] <= wr_active_r;
                        dq_o[g] <= wr_active_r ? wr_hold_r[g].data.fall : '0;
                        dm_o[g] <= wr_active_r & wr_hold_r[g].mask[0];
                    end
                end
            end

            // write strobe from the unshifted divider edge
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    dqs_o[g] <= 1'b0;
                    dqs_oe[g] <= 1'b0;
                end
                else if (base_tick)
                begin
                    dqs_oe[g] <= wr_active_r;
                    dqs_o[g] <= wr_active_r & wr_second_r;
                end
            end
        end
    endgenerate

endmodule

/* testbench/ddrsc_top_properties.sv */
// concurrent checks on the capture path ports
`timescale 1ns/1ps
module ddrsc_top_properties
    import ddrsc_pkg::*;
#(
    parameter int unsigned NUM_GROUPS = MAX_GROUPS
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mem_is_fcram,
    input wire logic [NUM_GROUPS-1:0] dqs_i,
    input wire logic [NUM_GROUPS-1:0] dq_oe,
    input wire logic [NUM_GROUPS-1:0][DQ_WIDTH-1:0] dq_o,
    input wire logic [NUM_GROUPS-1:0] dm_o,
    input wire ddrsc_pair_t [NUM_GROUPS-1:0] rd_pair,
    input wire logic [NUM_GROUPS-1:0] rd_valid,
    input wire ddrsc_wr_t [NUM_GROUPS-1:0] wr_data,
    input wire logic wr_taken
);
    // ==========================================
    // port relations, group 0 stands for all
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> rd_valid == '0 && !wr_taken)
        else $error("outputs active after reset");
    a_valid_pulse: assert property (rd_valid[0] |=> !rd_valid[0])
        else $error("rd_valid longer than one cycle");
    a_pair_holds: assert property (!rd_valid[0] |-> $stable(rd_pair[0]))
        else $error("rd_pair moved without rd_valid");
    // slow strobes stretch the delay, hence the window
    a_fall_to_valid: assert property ($fell(dqs_i[0]) |-> ##[8:14] rd_valid[0])
        else $error("no word pair after falling strobe");
    a_taken_pulse: assert property (wr_taken |=> !wr_taken)
        else $error("wr_taken longer than one cycle");
    a_rise_launch: assert property (wr_taken |-> dq_oe[0]
        && dq_o[0] == $past(wr_data[0].data.rise) && dm_o[0] == $past(wr_data[0].mask[1]))
        else $error("rise byte not launched with wr_taken");
    a_fall_launch: assert property (wr_taken |-> ##8 dq_o[0] == $past(wr_data[0].data.fall, 9)
        && dm_o[0] == $past(wr_data[0].mask[0], 9))
        else $error("fall byte not launched half a period later");
    a_oe_stands: assert property (wr_taken |-> dq_oe[0] [*8] ##1 dq_oe[0] [*7])
        else $error("dq_oe dropped inside a pair");
    a_idle_mask: assert property (!dq_oe[0] |-> !dm_o[0])
        else $error("mask driven while not writing");

    c_read_ddr: cover property (rd_valid[0] && !mem_is_fcram);
    c_read_fcram: cover property (rd_valid[0] && mem_is_fcram);
    c_write_b2b: cover property (wr_taken ##16 wr_taken);
endmodule

bind ddrsc_top ddrsc_top_properties #(.NUM_GROUPS(NUM_GROUPS)) u_props (
    .clk(clk), .rst_n(rst_n), .mem_is_fcram(mem_is_fcram), .dqs_i(dqs_i),
    .dq_oe(dq_oe), .dq_o(dq_o), .dm_o(dm_o), .rd_pair(rd_pair),
    .rd_valid(rd_valid), .wr_data(wr_data), .wr_taken(wr_taken)
);

/* testbench/ddrsc_mem_model.sv */
// behavioural memory returning one strobed read burst per go
`timescale 1ns/1ps
module ddrsc_mem_model
    import ddrsc_pkg::*;
#(
    parameter int unsigned NUM_GROUPS = MAX_GROUPS
)(
    input wire logic go,
    input wire logic slow,
    input wire logic [7:0] seed,
    output logic [NUM_GROUPS-1:0] dqs,
    output logic [NUM_GROUPS-1:0][DQ_WIDTH-1:0] dq
);
    // ==========================================
    // burst of four beats, byte = seed + 16*group + beat
    int half;
    initial
    begin
        dqs = '0;
        dq = '0;
    end
    always @(posedge go)
    begin
        half = slow ? 120 : 80;
        #3;
        for (int b = 0; b < 4; b++)
        begin
            for (int g = 0; g < NUM_GROUPS; g++)
            begin
                dqs[g] = (b % 2 == 0);
                dq[g] = seed + 8'(g * 16 + b);
            end
            #(half);
        end
        // strobe parks low; released data must not look like the last byte
        dqs = '0;
        dq = ~dq;
    end
endmodule

/* testbench/ddrsc_top_tb.sv */
// self-checking bench for the strobe capture path
`timescale 1ns/1ps
module ddrsc_top_tb
    import ddrsc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mem_is_fcram = 1'b0;
    logic wr_en = 1'b0;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [7:0] seed = 8'h00;
    logic [MAX_GROUPS-1:0] dqs_i, dqs_o, dqs_oe, dq_oe, dm_o, rd_valid, mdqs;
    logic [MAX_GROUPS-1:0][DQ_WIDTH-1:0] dq_i, dq_o, mdq;
    ddrsc_pair_t [MAX_GROUPS-1:0] rd_pair;
    ddrsc_wr_t [MAX_GROUPS-1:0] wr_data = '0;
    logic wr_taken;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    ddrsc_top dut (
        .clk(clk), .rst_n(rst_n), .mem_is_fcram(mem_is_fcram), .dqs_i(dqs_i),
        .dq_i(dq_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dq_o(dq_o), .dq_oe(dq_oe),
        .dm_o(dm_o), .rd_pair(rd_pair), .rd_valid(rd_valid), .wr_en(wr_en),
        .wr_data(wr_data), .wr_taken(wr_taken)
    );
    ddrsc_mem_model mem (.go(go), .slow(slow), .seed(seed), .dqs(mdqs), .dq(mdq));

    // ==========================================
    // shared pins: whoever enables drives the wire
    always_comb
    begin
        for (int g = 0; g < MAX_GROUPS; g++)
        begin
            dqs_i[g] = dqs_oe[g] ? dqs_o[g] : mdqs[g];
            dq_i[g] = dq_oe[g] ? dq_o[g] : mdq[g];
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            results();
        end
    end

    // ==========================================
    // read burst: two word pairs on every group
    task automatic t_read(input logic fc, input logic sl, input logic [7:0] sd);
        int n;
        logic [7:0] r;
        @(negedge clk);
        mem_is_fcram = fc;
        slow = sl;
        seed = sd;
        go = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            while (rd_valid[0] !== 1'b1 && n < 80)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            check("rd_valid", 16'h00FF, 16'(rd_valid));
            for (int g = 0; g < MAX_GROUPS; g++)
            begin
                r = sd + 8'(g * 16 + 2 * k);
                check("rd_pair", {r, r + 8'h01}, rd_pair[g]);
            end
            @(posedge clk);
            #1;
        end
        @(negedge clk);
        go = 1'b0;
        // gap past the period filter so the next burst starts fresh
        repeat (300) @(negedge clk);
        $display("read test done fcram=%0b slow=%0b", fc, sl);
    endtask

    // ==========================================
    // two back-to-back write pairs
    task automatic t_write();
        int n;
        logic [1:0] lvl;
        @(negedge clk);
        for (int g = 0; g < MAX_GROUPS; g++)
            wr_data[g] = {8'hA0 + 8'(g), 8'h50 + 8'(g), 2'b10};
        wr_en = 1'b1;
        n = 0;
        while (wr_taken !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("dq_oe", 16'h00FF, 16'(dq_oe));
        check("dm_rise", 16'h00FF, 16'(dm_o));
        for (int g = 0; g < MAX_GROUPS; g++)
            check("dq_rise", 16'(8'hA0 + 8'(g)), 16'(dq_o[g]));
        @(negedge clk);
        for (int g = 0; g < MAX_GROUPS; g++)
            wr_data[g] = {8'h30 + 8'(g), 8'hC0 + 8'(g), 2'b01};
        lvl = 2'b00;
        for (n = 1; n < 40; n++)
        begin
            @(posedge clk);
            #1;
            if (dqs_oe[0] === 1'b1)
                lvl = lvl | (dqs_o[0] ? 2'b10 : 2'b01);
            if (n == 8)
            begin
                check("dm_fall", 16'(dm_o), 16'h0000);
                for (int g = 0; g < MAX_GROUPS; g++)
                    check("dq_fall", 16'(8'h50 + 8'(g)), 16'(dq_o[g]));
            end
            if (wr_taken === 1'b1)
                break;
        end
        check("pair_gap", 16'h0010, 16'(n));
        check("strobe_lvl", 16'h0003, 16'(lvl));
        check("dm_rise2", 16'h0000, 16'(dm_o));
        check("dq_rise2", 16'h0030, 16'(dq_o[0]));
        @(negedge clk);
        wr_en = 1'b0;
        repeat (30) @(posedge clk);
        #1;
        check("idle_oe", 16'h0000, 16'(dq_oe | dqs_oe | dm_o));
        $display("write test done");
    endtask

    initial
    begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        check("reset_oe", 16'h0000, 16'(dq_oe | dqs_oe));
        t_read(1'b0, 1'b0, 8'h10);
        t_read(1'b1, 1'b0, 8'h40);
        t_read(1'b0, 1'b1, 8'h70);
        t_read(1'b1, 1'b1, 8'h90);
        t_write();
        results();
    end
endmodule
